// file: src/memc_params.svh
`ifndef MEMC_PARAMS_SVH
`define MEMC_PARAMS_SVH
`define MEMC_MAP_BASE     9'h000
`define MEMC_HCAM_BASE    9'h080
`define MEMC_HDAT_BASE    9'h100
`define MEMC_STAT_OFF     9'h180
`define MEMC_MAP_OUT_BIT  0
`define MEMC_HCAM_EN_BIT  0
`define MEMC_STAT_OVF_BIT 1'b0
`define MEMC_STAT_DBL_BIT 1'b1
`define MEMC_STAT_CNT_LSB 8
`define MEMC_MAP_OUT_RST  1'b1
`define MEMC_ACK_LAT      4
`endif

// file: src/memc_pkg.sv
package memc_pkg;
  typedef enum logic [4:0] {
    MEMC_ST_IDLE = 5'h01,
    MEMC_ST_XPH  = 5'h02,
    MEMC_ST_YPH  = 5'h04,
    MEMC_ST_DAT  = 5'h08,
    MEMC_ST_ACK  = 5'h10
  } memc_state_t;

  // bit numbers follow the bus convention: bit 3 is the least significant address bit
  typedef struct packed {
    logic        byte_mode;
    logic        half_mode;
    logic [26:0] laddr;
    logic [2:0]  func;
  } memc_baddr_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    memc_baddr_t addr;
    logic [31:0] wdata;
  } memc_bus_req_t;

  typedef struct packed {
    logic [3:0] cs;
    logic [6:0] y;
    logic [7:0] x;
  } memc_phys_t;

  typedef struct packed {
    logic [31:0] data;
    logic        single;
    logic        double;
  } memc_ecc_t;
endpackage : memc_pkg

// file: src/memc_top.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`include "memc_params.svh"
module memc_top
  import memc_pkg::*;
#(
  parameter int NMAP  = 32,
  parameter int NHEAL = 32
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire memc_bus_req_t bus_req,
  output logic               bus_ack,
  output logic      [31:0]   bus_rdata,
  output logic               halt,
  output logic      [3:0]    mem_cs_n,
  output logic      [7:0]    mem_addr,
  output logic               mem_we_n,
  output logic      [38:0]   mem_dq_o,
  output logic               mem_dq_oe_n,
  input  wire logic [38:0]   mem_dq_i
);

  function automatic logic [6:0] memc_enc(input logic [31:0] d);
    logic [6:0] c;
    int         k;
    c = 7'h00;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 6; b++) begin
          if (p[b]) c[b] = c[b] ^ d[k[4:0]];
        end
        k++;
      end
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction : memc_enc

  function automatic memc_ecc_t memc_dec(input logic [38:0] w);
    memc_ecc_t  r;
    logic [6:0] c;
    logic [5:0] syn;
    logic       par;
    int         k;
    c        = memc_enc(w[31:0]);
    syn      = c[5:0] ^ w[37:32];
    par      = ^w;
    r.data   = w[31:0];
    r.single = par;
    r.double = (syn != 6'h00) && !par;
    k        = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (par && (p[5:0] == syn)) r.data[k[4:0]] = ~r.data[k[4:0]];
        k++;
      end
    end
    return r;
  endfunction : memc_dec

  memc_state_t       st_r;
  logic [14:0]       map_cmp_r [NMAP];
  logic [NMAP-1:0]   map_out_r;
  logic [18:0]       hl_addr_r [NHEAL];
  logic [31:0]       hl_data_r [NHEAL];
  logic [NHEAL-1:0]  hl_en_r;
  logic [NMAP-1:0]   map_hit;
  logic [NHEAL-1:0]  heal_hit;
  logic [4:0]        map_idx;
  logic              map_any;
  logic [4:0]        heal_idx;
  logic              heal_any;
  logic [4:0]        free_idx;
  logic              any_free;
  logic [5:0]        used_cnt;
  memc_phys_t        phys_nxt;
  memc_phys_t        phys_r;
  logic              we_r;
  logic [31:0]       wdata_r;
  logic              taken;
  memc_ecc_t         dec;
  logic              dat_rd;
  logic              fill;
  logic              ovf_r;
  logic              dbl_r;
  logic              apb_wr;
  logic [8:0]        aoff;
  logic              a_map;
  logic              a_hcam;
  logic              a_hdat;
  logic              a_stat;
  logic [4:0]        aidx;
  logic [31:0]       prdata_r;
  logic [31:0]       rsel;

  // associative compare of the mapped logical bits against every register
  for (genvar g = 0; g < NMAP; g++) begin : g_map
    assign map_hit[g] = (map_cmp_r[g] == bus_req.addr[17:3]);
  end
  for (genvar g = 0; g < NHEAL; g++) begin : g_heal
    assign heal_hit[g] = hl_en_r[g] && (hl_addr_r[g] == phys_r);
  end

  always_comb begin
    map_idx  = 5'h00;
    map_any  = 1'b0;
    heal_idx = 5'h00;
    heal_any = 1'b0;
    free_idx = 5'h00;
    any_free = 1'b0;
    used_cnt = 6'h00;
    for (int i = NMAP - 1; i >= 0; i--) begin
      if (map_hit[i]) begin
        map_idx = i[4:0];
        map_any = 1'b1;
      end
    end
    for (int i = NHEAL - 1; i >= 0; i--) begin
      if (heal_hit[i]) begin
        heal_idx = i[4:0];
        heal_any = 1'b1;
      end
      if (!hl_en_r[i]) begin
        free_idx = i[4:0];
        any_free = 1'b1;
      end
      used_cnt = used_cnt + {5'h00, hl_en_r[i]};
    end
  end

  // register index picks the row (groups of eight, high rows first) and the block
  always_comb begin
    phys_nxt.cs = 4'h0;
    phys_nxt.cs[2'd3 - map_idx[4:3]] = 1'b1;
    phys_nxt.y  = {map_idx[2], map_idx[1:0], bus_req.addr[21:18]};
    phys_nxt.x  = bus_req.addr[29:22];
  end

  // function code and width modes are never decoded and every access moves a full word
  assign taken  = (st_r == MEMC_ST_IDLE) && bus_req.valid && map_any
                  && !map_out_r[map_idx];
  assign dec    = memc_dec(mem_dq_i);
  assign dat_rd = (st_r == MEMC_ST_DAT) && !we_r;
  // a healed location never re-reports its known-bad RAM word
  assign fill   = dat_rd && !heal_any && dec.single && any_free;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= MEMC_ST_IDLE;
    end else begin
      case (st_r)
        MEMC_ST_IDLE: if (taken) st_r <= MEMC_ST_XPH;
        MEMC_ST_XPH:  st_r <= MEMC_ST_YPH;
        MEMC_ST_YPH:  st_r <= MEMC_ST_DAT;
        MEMC_ST_DAT:  st_r <= MEMC_ST_ACK;
        MEMC_ST_ACK:  st_r <= MEMC_ST_IDLE;
        default:      st_r <= MEMC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_r  <= '0;
      we_r    <= 1'b0;
      wdata_r <= 32'h0000_0000;
    end else if (taken) begin
      phys_r  <= phys_nxt;
      we_r    <= bus_req.we;
      wdata_r <= bus_req.wdata;
    end
  end

  // memory pins: X then Y on the shared lines, row select held through the data cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_cs_n    <= 4'hf;
      mem_addr    <= 8'h00;
      mem_we_n    <= 1'b1;
      mem_dq_o    <= 39'h00_0000_0000;
      mem_dq_oe_n <= 1'b1;
    end else begin
      if (taken) begin
        mem_cs_n    <= ~phys_nxt.cs;
        mem_addr    <= phys_nxt.x;
        mem_dq_o    <= {memc_enc(bus_req.wdata), bus_req.wdata};
        mem_dq_oe_n <= !bus_req.we;
      end else if (st_r == MEMC_ST_XPH) begin
        mem_addr <= {1'b0, phys_r.y};
      end else if (st_r == MEMC_ST_YPH) begin
        mem_we_n <= !we_r;
      end else if (st_r == MEMC_ST_DAT) begin
        mem_cs_n    <= 4'hf;
        mem_we_n    <= 1'b1;
        mem_dq_oe_n <= 1'b1;
      end
    end
  end

  // correction and substitution happen in the same edge as a plain read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ack   <= 1'b0;
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_ack <= (st_r == MEMC_ST_DAT);
      if (dat_rd) begin
        bus_rdata <= heal_any ? hl_data_r[heal_idx] : dec.data;
      end
    end
  end

  // hardware fill wins over a software write to the same entry in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hl_en_r <= '0;
      for (int i = 0; i < NHEAL; i++) begin
        hl_addr_r[i] <= 19'h0_0000;
        hl_data_r[i] <= 32'h0000_0000;
      end
    end else begin
      if (apb_wr && a_hcam) begin
        hl_en_r[aidx]   <= pwdata[`MEMC_HCAM_EN_BIT];
        hl_addr_r[aidx] <= pwdata[19:1];
      end
      if (apb_wr && a_hdat) hl_data_r[aidx] <= pwdata;
      if ((st_r == MEMC_ST_DAT) && we_r && heal_any) begin
        hl_data_r[heal_idx] <= wdata_r;
      end
      if (fill) begin
        hl_en_r[free_idx]   <= 1'b1;
        hl_addr_r[free_idx] <= phys_r;
        hl_data_r[free_idx] <= dec.data;
      end
    end
  end

  // sticky flags: a new event beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_r <= 1'b0;
      dbl_r <= 1'b0;
    end else begin
      if (apb_wr && a_stat && pwdata[`MEMC_STAT_OVF_BIT]) ovf_r <= 1'b0;
      if (apb_wr && a_stat && pwdata[`MEMC_STAT_DBL_BIT]) dbl_r <= 1'b0;
      if (dat_rd && !heal_any && dec.single && (!any_free || (used_cnt == 6'd31))) begin
        ovf_r <= 1'b1;
      end
      if (dat_rd && !heal_any && dec.double) dbl_r <= 1'b1;
    end
  end
  assign halt = dbl_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_out_r <= {NMAP{`MEMC_MAP_OUT_RST}};
      for (int i = 0; i < NMAP; i++) map_cmp_r[i] <= 15'h0000;
    end else if (apb_wr && a_map) begin
      map_cmp_r[aidx] <= pwdata[17:3];
      map_out_r[aidx] <= pwdata[`MEMC_MAP_OUT_BIT];
    end
  end

  // a bare literal cannot be part-selected, so the window bases live in sized constants
  localparam logic [8:0] MAP_BASE  = `MEMC_MAP_BASE;
  localparam logic [8:0] HCAM_BASE = `MEMC_HCAM_BASE;
  localparam logic [8:0] HDAT_BASE = `MEMC_HDAT_BASE;
  localparam logic [8:0] STAT_OFF  = `MEMC_STAT_OFF;

  // apb slave: zero wait states, read data captured in the setup cycle
  assign aoff   = paddr[8:0];
  assign aidx   = paddr[6:2];
  assign a_map  = (paddr[11:9] == 3'h0) && (aoff[8:7] == MAP_BASE[8:7]);
  assign a_hcam = (paddr[11:9] == 3'h0) && (aoff[8:7] == HCAM_BASE[8:7]);
  assign a_hdat = (paddr[11:9] == 3'h0) && (aoff[8:7] == HDAT_BASE[8:7]);
  assign a_stat = (paddr[11:9] == 3'h0) && (aoff == STAT_OFF);
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(a_map || a_hcam || a_hdat || a_stat);
  assign prdata = prdata_r;

  always_comb begin
    rsel = 32'h0000_0000;
    if (a_map) begin
      rsel[17:3]               = map_cmp_r[aidx];
      rsel[`MEMC_MAP_OUT_BIT]  = map_out_r[aidx];
    end else if (a_hcam) begin
      rsel[19:1]               = hl_addr_r[aidx];
      rsel[`MEMC_HCAM_EN_BIT]  = hl_en_r[aidx];
    end else if (a_hdat) begin
      rsel = hl_data_r[aidx];
    end else if (a_stat) begin
      rsel[`MEMC_STAT_OVF_BIT] = ovf_r;
      rsel[`MEMC_STAT_DBL_BIT] = dbl_r;
      rsel[`MEMC_STAT_CNT_LSB +: 6] = used_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rsel;
    end
  end

  localparam int ACK_LAT = `MEMC_ACK_LAT;

  sequence s_xy;
    (mem_addr == phys_r.x) ##1 (mem_addr == {1'b0, phys_r.y});
  endsequence
  sequence s_rd_single;
    dat_rd && !heal_any && dec.single;
  endsequence

  AST_NOMATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == MEMC_ST_IDLE) && bus_req.valid && !map_any |=> (st_r == MEMC_ST_IDLE))
    else $error("access taken with no mapper match");
  AST_MAPOUT: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == MEMC_ST_IDLE) && map_any && map_out_r[map_idx] |=> (st_r == MEMC_ST_IDLE) && mem_cs_n == 4'hf)
    else $error("mapped-out block was accessed");
  AST_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
    taken |-> !bus_ack [*4] ##1 bus_ack)
    else $error("answer not at fixed latency");
  AST_XY_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    taken |=> s_xy)
    else $error("address phases out of order");
  AST_ROW: assert property (@(posedge pclk) disable iff (!presetn)
    taken |=> mem_cs_n == ~(4'h8 >> $past(map_idx[4:3])))
    else $error("wrong row select");
  AST_ECC_WR: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_dq_oe_n |-> mem_dq_o[38:32] == memc_enc(mem_dq_o[31:0]))
    else $error("check bits do not match data");
  AST_FILL: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_single and any_free |=> used_cnt == $past(used_cnt) + 6'd1)
    else $error("corrected word not healed");
  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && !heal_any && dec.double |=> halt [*2])
    else $error("double error did not halt");
  AST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_single and !any_free |=> ovf_r && $stable(hl_en_r))
    else $error("overflow not flagged or healer changed");
  AST_SUBST: assert property (@(posedge pclk) disable iff (!presetn)
    dat_rd && heal_any |=> bus_rdata == $past(hl_data_r[heal_idx]))
    else $error("healer word not substituted");
  AST_ACK_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    taken |-> ##ACK_LAT bus_ack ##1 !bus_ack)
    else $error("answer is not a single pulse");
  AST_X_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    taken |=> mem_addr == $past(bus_req.addr[29:22]))
    else $error("x phase does not carry the unmapped bits");
  AST_Y_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    taken |=> ##1 (mem_addr[3:0] == $past(bus_req.addr[21:18], 2)) && !mem_addr[7])
    else $error("y phase low bits or top bit wrong");
  // the pins must rest between accesses, otherwise a refused request would leak a cycle
  AST_IDLE_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == MEMC_ST_IDLE) |-> (mem_cs_n == 4'hf) && mem_we_n && mem_dq_oe_n)
    else $error("memory pins active while idle");
  AST_ONE_ROW: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_cs_n != 4'hf) |-> $onehot(~mem_cs_n))
    else $error("more than one row selected");
  AST_DQ_WE: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_we_n |-> !mem_dq_oe_n && (st_r == MEMC_ST_DAT))
    else $error("write strobe outside the data cycle");
  // a write to a healed word must land in the healer too, or the next read returns stale data
  AST_HEAL_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == MEMC_ST_DAT) && we_r && heal_any |=> hl_data_r[$past(heal_idx)] == $past(wdata_r))
    else $error("write to healed word missed the healer");

endmodule : memc_top

// file: sim/memc_ram_model.sv
`timescale 1ns/100ps
module memc_ram_model (
  input  wire logic        pclk,
  input  wire logic [3:0]  mem_cs_n,
  input  wire logic [7:0]  mem_addr,
  input  wire logic        mem_we_n,
  input  wire logic [38:0] mem_dq_o,
  input  wire logic [38:0] flip,
  output logic      [38:0] mem_dq_i
);
  logic [38:0] mem [65536];
  logic [1:0]  ph_r = 2'd0;
  logic [7:0]  x_r;
  logic [6:0]  y_r;
  logic [1:0]  row;
  logic [15:0] idx;

  assign row = ~mem_cs_n[3] ? 2'd3 : (~mem_cs_n[2] ? 2'd2 : (~mem_cs_n[1] ? 2'd1 : 2'd0));
  // the chips never see the top y bit
  assign idx = {row, y_r[5:0], x_r};
  // outside the data cycle and the cycle after it the bus shows the inverse, so a stale sample cannot pass
  assign mem_dq_i = (ph_r == 2'd2) ? (mem[idx] ^ flip) : ~mem[idx];

  always @(posedge pclk) begin
    if (mem_cs_n == 4'hf) begin
      ph_r <= 2'd0;
    end else if (ph_r == 2'd0) begin
      x_r  <= mem_addr; // x phase first
      ph_r <= 2'd1;
    end else if (ph_r == 2'd1) begin
      y_r  <= mem_addr[6:0];
      ph_r <= 2'd2;
    end else if (!mem_we_n) begin
      mem[idx] <= mem_dq_o;
    end
  end
endmodule : memc_ram_model

// file: sim/memc_top_tb.sv
`timescale 1ns/100ps
module memc_top_tb;
  import memc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          bus_ack, halt, mem_we_n, mem_dq_oe_n;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, bus_rdata;
  logic [3:0]    mem_cs_n;
  logic [7:0]    mem_addr;
  logic [38:0]   mem_dq_o, mem_dq_i, flip;
  memc_bus_req_t bus_req;
  int            n_mismatch, total_checks;
  logic [4:0]    tbl [4] = '{5'd0, 5'd9, 5'd18, 5'd27};

  memc_top #(.NMAP(32), .NHEAL(32)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_req, .bus_ack, .bus_rdata, .halt, .mem_cs_n, .mem_addr,
    .mem_we_n, .mem_dq_o, .mem_dq_oe_n, .mem_dq_i);
  memc_ram_model ram (.pclk, .mem_cs_n, .mem_addr, .mem_we_n, .mem_dq_o, .flip, .mem_dq_i);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_of_test;
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_mismatch++;
      end_of_test();
    end
    if (!w) chk(prdata, exp);
    chk(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] baddr(input logic [14:0] tag, input logic [3:0] y, input logic [7:0] x);
    return {2'b00, x, y, tag, 3'h5}; // function code rides along unused
  endfunction : baddr

  function automatic logic [6:0] ecc(input logic [31:0] d);
    logic [6:0] c;
    int         k;
    c = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 6; b++) if (p[b]) c[b] ^= d[k];
        k++;
      end
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction : ecc

  // d is the write data, or the expected read data
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d, input logic ack,
                     input logic [4:0] mi, input logic [38:0] fl);
    int         k;
    int         ns;
    logic [7:0] ad [2];
    logic       got;
    @(posedge pclk);
    flip <= fl;
    bus_req <= {1'b1, we, a, d};
    ns = 0;
    got = 1'b0;
    for (k = 0; k < 12 && !got; k++) begin
      @(negedge pclk);
      if (mem_cs_n !== 4'hf && ns < 2) begin
        ad[ns] = mem_addr;
        ns++;
        if (ns == 1) chk(mem_cs_n, 4'(~(4'h8 >> mi[4:3])));
      end
      got = (bus_ack === 1'b1);
    end
    chk(got, ack);
    if (ack && !got) end_of_test();
    if (ack) begin
      chk(k, 5);
      chk(ad[0], a[29:22]);
      chk(ad[1], {1'b0, mi[2], mi[1:0], a[21:18]});
      if (!we) chk(bus_rdata, d);
    end else chk(ns, 0);
    @(posedge pclk);
    bus_req.valid <= 1'b0;
    flip <= '0;
  endtask : bus

  initial begin
    int          j;
    logic [31:0] a, wd;
    logic [7:0]  x;
    logic [3:0]  y;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bus_req = '0;
    flip = '0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h080, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h180, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h200, 32'h0, 32'h0, 1'b1);
    bus(1'b0, baddr(15'h0, 4'h0, 8'h00), 32'h0, 1'b0, 5'd0, '0);
    for (j = 0; j < 4; j++) apb(1'b1, 12'(tbl[j] * 4), {14'h0, 15'(tbl[j] + 1), 3'h0}, 0, 1'b0);
    apb(1'b1, 12'h010, {14'h0, 15'h55, 3'h1}, 32'h0, 1'b0);
    bus(1'b0, baddr(15'h55, 4'h0, 8'h00), 32'h0, 1'b0, 5'd4, '0);
    bus(1'b0, baddr(15'h777, 4'h0, 8'h00), 32'h0, 1'b0, 5'd0, '0);
    for (j = 0; j < 4; j++) begin
      x = 8'h3c + 8'(j);
      y = 4'h9 - 4'(j);
      a = baddr(15'(tbl[j] + 1), y, x);
      wd = 32'h1234_5678 ^ (32'h0101_0101 * j);
      bus(1'b1, a, wd, 1'b1, tbl[j], '0);
      chk(ram.mem[{2'd3 - tbl[j][4:3], tbl[j][1:0], y, x}], {ecc(wd), wd});
      bus(1'b0, a, wd, 1'b1, tbl[j], '0);
    end
    a = baddr(15'h1, 4'h9, 8'h3c);
    bus(1'b0, a, 32'h1234_5678, 1'b1, 5'd0, 39'h20);
    apb(1'b0, 12'h180, 32'h0, 32'h100, 1'b0);
    apb(1'b0, 12'h080, 32'h0, {12'h0, 4'h8, 7'h09, 8'h3c, 1'b1}, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 32'h1234_5678, 1'b0);
    bus(1'b0, a, 32'h1234_5678, 1'b1, 5'd0, 39'h3);
    chk(halt, 1'b0);
    bus(1'b0, baddr(15'ha, 4'h8, 8'h3d), 32'h1335_5779 ^ 32'h3, 1'b1, 5'd9, 39'h3);
    chk(halt, 1'b1);
    apb(1'b0, 12'h180, 32'h0, 32'h102, 1'b0);
    apb(1'b1, 12'h180, 32'h2, 32'h0, 1'b0);
    @(negedge pclk);
    chk(halt, 1'b0);
    for (j = 1; j < 32; j++) begin
      a = baddr(15'h1, 4'hf, 8'(j));
      bus(1'b1, a, 32'(j), 1'b1, 5'd0, '0);
      bus(1'b0, a, 32'(j), 1'b1, 5'd0, 39'(1) << j);
    end
    bus(1'b1, baddr(15'h1, 4'hf, 8'h01), 32'h0bad_f00d, 1'b1, 5'd0, '0);
    bus(1'b0, baddr(15'h1, 4'hf, 8'h01), 32'h0bad_f00d, 1'b1, 5'd0, 39'h3);
    apb(1'b0, 12'h180, 32'h0, 32'h2001, 1'b0);
    a = baddr(15'h1, 4'he, 8'h00);
    bus(1'b1, a, 32'h00c0_ffee, 1'b1, 5'd0, '0);
    bus(1'b0, a, 32'h00c0_ffee, 1'b1, 5'd0, 39'h40);
    apb(1'b0, 12'h180, 32'h0, 32'h2001, 1'b0);
    apb(1'b1, 12'h180, 32'h1, 32'h0, 1'b0);
    apb(1'b0, 12'h180, 32'h0, 32'h2000, 1'b0);
    apb(1'b1, 12'h080, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h080, 32'h0, 32'h0, 1'b0);
    end_of_test();
  end
endmodule : memc_top_tb
